// ---- shared/ssd_pkg.sv ----
// Constants and types for the sensor slave command decoder.
// Assumes a framed command word arrives already CRC-checked from the bus front end.
package ssd_pkg;
  localparam int unsigned ADC_BITS       = 10;
  localparam int unsigned RESP_BITS      = 16;
  localparam logic [3:0]  CMD_CONV_ONE   = 4'h5;
  localparam logic [3:0]  CMD_PIN_CTRL   = 4'h3;
  localparam logic [3:0]  CMD_IDENT      = 4'h4;
  localparam logic [3:0]  ADDR_GLOBAL    = 4'h0;
  localparam int unsigned CMD_LSB        = 0;
  localparam int unsigned ADDR_LSB       = 4;
  localparam int unsigned DATA_LSB       = 8;
  localparam int unsigned LVL_LSB        = 4;
  localparam int unsigned DIR_LSB        = 0;
  localparam logic [2:0]  DIR_RESET      = 3'h0;
  localparam logic [2:0]  LVL_RESET      = 3'h0;
  // Silicon version; value is arbitrary, low bit kept zero.
  localparam logic [3:0]  SILICON_VER    = 4'ha;
  typedef enum logic [1:0] {
    FMT_LONG,
    FMT_SHORT8,
    FMT_SHORT10
  } ssd_fmt_t;
endpackage

// ---- src/ssd_fuse_check.sv ----
// Fuse parity check performed once after reset release.
// Assumes fuse bits are static on-chip levels in the clock domain.
`timescale 1ns/1ns
`default_nettype none
module ssd_fuse_check #(
  parameter int unsigned FUSE_BITS = 16
) (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_n_i,
  input  wire logic [FUSE_BITS-1:0] fuse_bits_i,
  input  wire logic                 fuse_parity_i,
  output logic                      fuse_parity_error_o
);
  import ssd_pkg::*;
  typedef struct packed {
    logic done;
    logic err;
  } ssd_fuse_st_t;
  ssd_fuse_st_t st_r;
  ssd_fuse_st_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (!st_r.done) begin
      st_nxt.done = 1'b1;
      st_nxt.err  = (^fuse_bits_i) != fuse_parity_i;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign fuse_parity_error_o = st_r.err;
  a_fuse_once: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $past(st_r.done) |-> $stable(st_r.err)) else $error("Fuse flag changed after check.");
endmodule
`default_nettype wire

// ---- src/ssd_pin_ctrl.sv ----
// Three logic pins with direction and level registers.
// Assumes pin inputs are sampled elsewhere; this only drives.
`timescale 1ns/1ns
`default_nettype none
module ssd_pin_ctrl (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       clear_i,
  input  wire logic       load_i,
  input  wire logic [2:0] dir_i,
  input  wire logic [2:0] lvl_i,
  output logic [2:0]      pin_direction_bits_o,
  output logic [2:0]      pin_level_bits_o,
  output logic [2:0]      pin_out_o,
  output logic [2:0]      pin_oe_o
);
  import ssd_pkg::*;
  typedef struct packed {
    logic [2:0] dir;
    logic [2:0] lvl;
    logic [2:0] out;
    logic [2:0] oe;
  } ssd_pin_st_t;
  ssd_pin_st_t st_r;
  ssd_pin_st_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (clear_i) begin
      st_nxt.dir = DIR_RESET;
      st_nxt.lvl = LVL_RESET;
    end else if (load_i) begin
      st_nxt.dir = dir_i;
      st_nxt.lvl = lvl_i;
    end
    st_nxt.oe  = st_nxt.dir;
    st_nxt.out = st_nxt.lvl & st_nxt.dir;
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign pin_direction_bits_o = st_r.dir;
  assign pin_level_bits_o     = st_r.lvl;
  assign pin_out_o            = st_r.out;
  assign pin_oe_o             = st_r.oe;
  a_pin_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    clear_i |=> (pin_oe_o == 3'h0)) else $error("Clear left a pin driven.");
  a_pin_input: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (pin_out_o & ~pin_oe_o) == 3'h0) else $error("Input pin has level.");
  a_pin_load: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (load_i && !clear_i) |=> (pin_oe_o == $past(dir_i) &&
    pin_out_o == ($past(lvl_i) & $past(dir_i)))) else $error("Pin load wrong.");
endmodule
`default_nettype wire

// ---- src/ssd_cmd_decoder.sv ----
// Command decoder and response builder for the sensor slave.
// Assumes the bus front end delivers checked command words, appends CRC to responses,
// handles init and clear, and gives a one-cycle pulse at each new message start.
// Functional notes
// - A valid second-channel request starts one 10-bit conversion of that input.
// - Code 0101 is the conversion request in long, 8-bit and 10-bit short words.
// - Conversion response: long has address, zeros, bits 9..2; short8 9..2; short10 all.
// - Addressed commands act only when the address matches the initialized address.
// - Conversion and identification requests to address 0000 are ignored.
// - Pin-control and identification are long-word only; short forms get nothing.
// - Pin-control response goes out in the next bus message.
// - Direction bit 1 makes the pin an output driven at its level bit.
// - Direction bit 0 makes the pin an input; its level bit has no effect.
// - Pin-control code 0011: levels in data 6..4, directions 2..0, 7 and 3 ignored.
// - Pin-control response echoes programmed direction and commanded level bits.
// - Pin-control to 0000 applies to all slaves and sends no response.
// - Reset or clear forces all direction bits to 0.
// - Code 0100 returns identification data in the next message.
// - Identification response: address, zeros, version, three zeros, fuse parity flag.
// - After power-up fuse parity is checked against stored parity; mismatch sets flag.
// - No command is answered until the address has been initialized.
// - Clear addressed here or to 0000 resets state and sends no response.
// - Every command and response carries a 4-bit CRC, handled by the front end.
`timescale 1ns/1ns
`default_nettype none
module ssd_cmd_decoder #(
  parameter int unsigned FUSE_BITS = 16
) (
  input  wire logic                          mclk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          cmd_valid_i,
  input  wire logic [15:0]                   cmd_word_i,
  input  wire ssd_pkg::ssd_fmt_t             cmd_fmt_i,
  input  wire logic                          msg_start_i,
  input  wire logic                          clear_i,
  input  wire logic                          addr_valid_i,
  input  wire logic [3:0]                    node_addr_i,
  output logic                               adc_start_o,
  input  wire logic                          adc_done_i,
  input  wire logic [ssd_pkg::ADC_BITS-1:0]  adc_result_i,
  input  wire logic [FUSE_BITS-1:0]          fuse_bits_i,
  input  wire logic                          fuse_parity_i,
  output logic                               resp_valid_o,
  output logic [ssd_pkg::RESP_BITS-1:0]      resp_word_o,
  output ssd_pkg::ssd_fmt_t                  resp_fmt_o,
  output logic [2:0]                         pin_direction_bits_o,
  output logic [2:0]                         pin_out_o,
  output logic [2:0]                         pin_oe_o,
  output logic                               fuse_parity_error_o
);
  import ssd_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_ARMED
  } ssd_state_t;

  typedef struct packed {
    ssd_state_t                state;
    logic                      adc_start;
    logic                      resp_valid;
    logic [RESP_BITS-1:0]      resp_word;
    logic [RESP_BITS-1:0]      pend_word;
    ssd_fmt_t                  pend_fmt;
    ssd_fmt_t                  resp_fmt;
    ssd_fmt_t                  conv_fmt;
  } ssd_dec_st_t;

  ssd_dec_st_t st_r;
  ssd_dec_st_t st_nxt;

  logic [3:0] cmd_code;
  logic [3:0] cmd_addr;
  logic [7:0] cmd_data;
  logic       addr_hit;
  logic       is_global;
  logic       is_long;
  logic       pin_load;
  logic [2:0] pin_level_bits;
  logic [2:0] pin_dir_bits;

  // The bus front end strips and checks the CRC, so only the bare fields arrive here.
  assign cmd_code  = cmd_word_i[CMD_LSB +: 4];
  assign cmd_addr  = cmd_word_i[ADDR_LSB +: 4];
  assign cmd_data  = cmd_word_i[DATA_LSB +: 8];
  assign is_global = (cmd_addr == ADDR_GLOBAL);
  assign addr_hit  = addr_valid_i && !is_global && (cmd_addr == node_addr_i);
  assign is_long   = (cmd_fmt_i == FMT_LONG);

  // Global pin control is applied even though it stays silent.
  assign pin_load = cmd_valid_i && addr_valid_i && is_long && (cmd_code == CMD_PIN_CTRL)
                    && (addr_hit || is_global);

  ssd_fuse_check #(
    .FUSE_BITS (FUSE_BITS)
  ) u_fuse (
    .mclk_i              (mclk_i),
    .rst_n_i             (rst_n_i),
    .fuse_bits_i         (fuse_bits_i),
    .fuse_parity_i       (fuse_parity_i),
    .fuse_parity_error_o (fuse_parity_error_o)
  );

  ssd_pin_ctrl u_pins (
    .mclk_i               (mclk_i),
    .rst_n_i              (rst_n_i),
    .clear_i              (clear_i),
    .load_i               (pin_load),
    .dir_i                (cmd_data[DIR_LSB +: 3]),
    .lvl_i                (cmd_data[LVL_LSB +: 3]),
    .pin_direction_bits_o (pin_dir_bits),
    .pin_level_bits_o     (pin_level_bits),
    .pin_out_o            (pin_out_o),
    .pin_oe_o             (pin_oe_o)
  );

  assign pin_direction_bits_o = pin_dir_bits;

  always_comb begin
    st_nxt            = st_r;
    st_nxt.adc_start  = 1'b0;
    if (msg_start_i) begin
      st_nxt.resp_valid = 1'b0;
    end
    if (clear_i) begin
      st_nxt.state      = ST_IDLE;
      st_nxt.resp_valid = 1'b0;
    end else begin
      unique case (st_r.state)
        ST_IDLE: begin
        end
        ST_CONV: begin
          if (adc_done_i) begin
            st_nxt.state = ST_ARMED;
            unique case (st_r.conv_fmt)
              FMT_LONG:    st_nxt.pend_word = {node_addr_i, 4'h0, adc_result_i[9:2]};
              FMT_SHORT8:  st_nxt.pend_word = {8'h00, adc_result_i[9:2]};
              FMT_SHORT10: st_nxt.pend_word = {6'h00, adc_result_i};
            endcase
            st_nxt.pend_fmt = st_r.conv_fmt;
          end
        end
        ST_ARMED: begin
          if (msg_start_i) begin
            st_nxt.state      = ST_IDLE;
            st_nxt.resp_valid = 1'b1;
            st_nxt.resp_word  = st_r.pend_word;
            st_nxt.resp_fmt   = st_r.pend_fmt;
          end
        end
      endcase
      if (cmd_valid_i && addr_hit) begin
        if (cmd_code == CMD_CONV_ONE) begin
          st_nxt.state     = ST_CONV;
          st_nxt.adc_start = 1'b1;
          st_nxt.conv_fmt  = cmd_fmt_i;
        end else if (is_long && cmd_code == CMD_PIN_CTRL) begin
          st_nxt.state     = ST_ARMED;
          st_nxt.pend_word = {node_addr_i, 4'h0, 1'b0, cmd_data[LVL_LSB +: 3],
                              1'b0, cmd_data[DIR_LSB +: 3]};
          st_nxt.pend_fmt  = FMT_LONG;
        end else if (is_long && cmd_code == CMD_IDENT) begin
          st_nxt.state     = ST_ARMED;
          st_nxt.pend_word = {node_addr_i, 4'h0, SILICON_VER, 3'h0,
                              fuse_parity_error_o};
          st_nxt.pend_fmt  = FMT_LONG;
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign adc_start_o  = st_r.adc_start;
  assign resp_valid_o = st_r.resp_valid;
  assign resp_word_o  = st_r.resp_word;
  assign resp_fmt_o   = st_r.resp_fmt;

  // Assertions.
  a_no_global_resp: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (cmd_valid_i && is_global && st_r.state == ST_IDLE && !clear_i) |=>
    st_r.state == ST_IDLE) else $error("Global command armed a response.");
  a_uninit_no_start: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (cmd_valid_i && !addr_valid_i) |=> !adc_start_o) else $error("Uninit start.");
  a_conv_start: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (cmd_valid_i && addr_hit && cmd_code == CMD_CONV_ONE && !clear_i) |=>
    (adc_start_o && st_r.state == ST_CONV)) else $error("Conversion not started.");
  a_short_refused: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (cmd_valid_i && !is_long && cmd_code != CMD_CONV_ONE && st_r.state == ST_IDLE) |=>
    st_r.state == ST_IDLE) else $error("Short-word form accepted.");
  a_send_next: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_r.state == ST_ARMED && msg_start_i && !clear_i && !cmd_valid_i) |=>
    (resp_valid_o && resp_word_o == $past(st_r.pend_word))) else $error("Response lost.");
  a_resp_one_msg: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (msg_start_i && st_r.state != ST_ARMED) |=> !resp_valid_o)
    else $error("Stale response.");
  a_ident_fmt: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (cmd_valid_i && addr_hit && is_long && cmd_code == CMD_IDENT && !clear_i) |=>
    st_r.pend_word[7:0] == {SILICON_VER, 3'h0, fuse_parity_error_o})
    else $error("Bad ident word.");
  a_clear_silent: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    clear_i |=> (!resp_valid_o && st_r.state == ST_IDLE)) else $error("Clear not silent.");
  a_pin_echo: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (pin_load && addr_hit && !clear_i) |=>
    st_r.pend_word[7:0] == {1'b0, pin_level_bits, 1'b0, pin_dir_bits})
    else $error("Pin echo mismatch.");
endmodule
`default_nettype wire

// ---- tb/ssd_adc_model.sv ----
// Behavioural converter facing the command decoder.
// Assumes start is a one-cycle pulse in the mclk_i domain.
`timescale 1ns/1ns
`default_nettype none
module ssd_adc_model #(
  parameter int DELAY = 3
) (
  input  wire logic       mclk_i,
  input  wire logic       start_i,
  input  wire logic [9:0] value_i,
  output logic            done_o,
  output logic [9:0]      result_o,
  output logic [7:0]      starts_o
);
  int cnt = 0;
  initial begin
    done_o = 1'b0;
    starts_o = 8'h00;
  end
  // Outside done the result is inverted, so a decoder sampling late sees wrong data.
  assign result_o = done_o ? value_i : ~value_i;
  always @(posedge mclk_i) begin
    done_o <= 1'b0;
    if (start_i) begin
      starts_o <= starts_o + 8'h01;
      cnt <= DELAY;
    end else if (cnt == 1) begin
      done_o <= 1'b1;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/sensor_slave_cmd_decoder_tb_top.sv ----
// Self-checking bench for the sensor slave command decoder.
// Assumes command words arrive checked and one command is sent per message.
`timescale 1ns/1ns
`default_nettype none
module sensor_slave_cmd_decoder_tb_top;
  import ssd_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        msg_start = 1'b0;
  logic        clear = 1'b0;
  logic        addr_valid = 1'b0;
  logic [15:0] cmd_word = 16'h0000;
  ssd_fmt_t    cmd_fmt = FMT_LONG;
  logic [15:0] fuse = 16'h00f1;
  logic        fuse_parity_error = 1'b1;
  logic [9:0]  adc_val = 10'h2b7;
  logic        adc_start, adc_done, resp_valid, fperr;
  logic [9:0]  adc_res;
  logic [15:0] resp_word;
  ssd_fmt_t    resp_fmt;
  logic [2:0]  dir, pout, poe;
  logic [7:0]  starts;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cycles = 0;

  initial begin
    forever #10 mclk_i = ~mclk_i;
  end

  ssd_cmd_decoder #(.FUSE_BITS(16)) u_ssd_cmd_decoder (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid), .cmd_word_i(cmd_word),
    .cmd_fmt_i(cmd_fmt), .msg_start_i(msg_start), .clear_i(clear),
    .addr_valid_i(addr_valid), .node_addr_i(4'h6), .adc_start_o(adc_start),
    .adc_done_i(adc_done), .adc_result_i(adc_res), .fuse_bits_i(fuse),
    .fuse_parity_i(fuse_parity_error), .resp_valid_o(resp_valid), .resp_word_o(resp_word),
    .resp_fmt_o(resp_fmt), .pin_direction_bits_o(dir), .pin_out_o(pout),
    .pin_oe_o(poe), .fuse_parity_error_o(fperr));

  ssd_adc_model #(.DELAY(3)) u_ssd_adc_model (
    .mclk_i(mclk_i), .start_i(adc_start), .value_i(adc_val), .done_o(adc_done),
    .result_o(adc_res), .starts_o(starts));

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset(input logic p);
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    fuse_parity_error <= p;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
  endtask

  task automatic send(input logic [3:0] code, input logic [3:0] addr, input logic [7:0] data,
                      input ssd_fmt_t fmt);
    @(posedge mclk_i);
    cmd_valid <= 1'b1;
    cmd_word <= {data, addr, code};
    cmd_fmt <= fmt;
    @(posedge mclk_i);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask

  // The response stands until the next message start, so a late look is still valid.
  task automatic slot(input logic v, input logic [15:0] w, input ssd_fmt_t f);
    @(posedge mclk_i);
    msg_start <= 1'b1;
    @(posedge mclk_i);
    msg_start <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk("resp_valid", {15'h0, v}, {15'h0, resp_valid});
    if (v) begin
      chk("resp_word", w, resp_word);
      chk("resp_fmt", {14'h0, f}, {14'h0, resp_fmt});
    end
  endtask

  task automatic pins(input logic [2:0] d, input logic [2:0] l);
    chk("dir", {13'h0, d}, {13'h0, dir});
    chk("oe", {13'h0, d}, {13'h0, poe});
    chk("out", {13'h0, d & l}, {13'h0, pout});
  endtask

  initial begin
    logic [15:0] cv [3];
    cv = '{16'h60ad, 16'h00ad, 16'h02b7};
    do_reset(1'b1);
    pins(3'h0, 3'h0);
    chk("fperr", 16'h0, {15'h0, fperr});
    send(CMD_PIN_CTRL, 4'h6, 8'h77, FMT_LONG);
    pins(3'h0, 3'h0);
    slot(1'b0, 16'h0, FMT_LONG);
    $display("test uninitialized ended");
    @(posedge mclk_i);
    addr_valid <= 1'b1;
    send(CMD_PIN_CTRL, 4'h6, 8'hd9, FMT_LONG);
    pins(3'h1, 3'h5);
    slot(1'b1, 16'h6051, FMT_LONG);
    send(CMD_PIN_CTRL, 4'h5, 8'h77, FMT_LONG);
    pins(3'h1, 3'h5);
    slot(1'b0, 16'h0, FMT_LONG);
    send(CMD_PIN_CTRL, 4'h6, 8'h77, FMT_SHORT8);
    pins(3'h1, 3'h5);
    slot(1'b0, 16'h0, FMT_LONG);
    send(CMD_PIN_CTRL, 4'h0, 8'h36, FMT_LONG);
    pins(3'h6, 3'h3);
    slot(1'b0, 16'h0, FMT_LONG);
    $display("test pin control ended");
    send(CMD_IDENT, 4'h6, 8'h00, FMT_LONG);
    slot(1'b1, {4'h6, 4'h0, SILICON_VER, 4'h0}, FMT_LONG);
    send(CMD_IDENT, 4'h6, 8'h00, FMT_SHORT10);
    slot(1'b0, 16'h0, FMT_LONG);
    send(CMD_IDENT, 4'h0, 8'h00, FMT_LONG);
    slot(1'b0, 16'h0, FMT_LONG);
    $display("test identification ended");
    for (int f = 0; f < 3; f++) begin
      send(CMD_CONV_ONE, 4'h6, 8'hff, ssd_fmt_t'(f));
      repeat (8) @(posedge mclk_i);
      chk("starts", 16'(f + 1), {8'h0, starts});
      slot(1'b1, cv[f], ssd_fmt_t'(f));
    end
    send(CMD_CONV_ONE, 4'h0, 8'h00, FMT_LONG);
    repeat (8) @(posedge mclk_i);
    chk("starts", 16'h3, {8'h0, starts});
    slot(1'b0, 16'h0, FMT_LONG);
    $display("test conversion ended");
    @(posedge mclk_i);
    clear <= 1'b1;
    @(posedge mclk_i);
    clear <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    pins(3'h0, 3'h0);
    do_reset(1'b0);
    chk("fperr", 16'h1, {15'h0, fperr});
    send(CMD_IDENT, 4'h6, 8'h00, FMT_LONG);
    slot(1'b1, {4'h6, 4'h0, SILICON_VER, 4'h1}, FMT_LONG);
    $display("test clear and fuse ended");
    conclude();
  end
endmodule
`default_nettype wire
